// ==== core/otcs_pkg.sv ====
// How it works
// - Two on-chip clock sources exist, a trimmable 10 MHz main oscillator and a 32 kHz slow oscillator.
// - The slow oscillator clocks suspend, drives the periodic wakeup and runs sequencing while the main clock is stopped.
// - Software can pick the slow oscillator as source of the interval timer clock and of the capture timer clock.
// - The slow oscillator runs either in a low-power mode or in a more accurate normal mode.
// - At power-on the main trim register holds the trim value for a 3.30V supply.
// - Table 2 holds main trim bytes for 3.30, 3.00, 2.85 and 2.70 V at slots fc to ff in that order.
// - Table 3 holds slow trim bytes for 3.30, 3.00, 2.85 and 2.70 V at slots f8 to fb in that order.
// - Reading table 0 returns the 16-bit silicon identifier, high byte at slot f8 and low byte at slot f9.
// - The table read uses only the three low bits of the table number and ignores the upper five.
package otcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OTCS_OFF_MAIN_TRIM = 8'h34;
  localparam logic [7:0] OTCS_OFF_MAIN_GAIN = 8'h38;
  localparam logic [7:0] OTCS_OFF_SLOW_TRIM = 8'h3c;
  localparam logic [7:0] OTCS_OFF_CLK_CFG = 8'h40;
  localparam logic [7:0] OTCS_OFF_TBL_CMD = 8'h44;
  localparam logic [7:0] OTCS_OFF_INTERVAL = 8'h48;
  localparam logic [7:0] OTCS_OFF_TBL_BUF = 8'h60;
  localparam logic [7:0] OTCS_OFF_TBL_END = 8'h7c;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int OTCS_CMD_BLK_LSB = 0;
  localparam int OTCS_CMD_KEY_LSB = 8;
  localparam int OTCS_CMD_OP_LSB = 16;
  localparam int OTCS_CMD_BUSY_BIT = 24;
  localparam int OTCS_CMD_ERR_BIT = 25;
  localparam logic [7:0] OTCS_TBL_KEY = 8'h3a;
  localparam logic [7:0] OTCS_TBL_OP = 8'h06;
  localparam int OTCS_SLOT_F8 = 0;
  localparam int OTCS_SLOT_F9 = 1;
  localparam int OTCS_SLOT_FA = 2;
  localparam int OTCS_SLOT_FB = 3;
  localparam int OTCS_SLOT_FC = 4;
  localparam int OTCS_SLOT_FD = 5;
  localparam int OTCS_SLOT_FE = 6;
  localparam int OTCS_SLOT_FF = 7;
  localparam logic [2:0] OTCS_TBL_ID = 3'h0;
  localparam logic [2:0] OTCS_TBL_MAIN = 3'h2;
  localparam logic [2:0] OTCS_TBL_SLOW = 3'h3;

  // ----------------------------------------------------------------
  // Supervisory table contents and reset values
  // ----------------------------------------------------------------
  // Arbitrary identifier value, not tied to any real part
  localparam logic [15:0] OTCS_SILICON_ID = 16'h5a17;
  localparam logic [7:0] OTCS_MTRIM_3V30 = 8'h80;
  localparam logic [7:0] OTCS_MTRIM_3V00 = 8'h84;
  localparam logic [7:0] OTCS_MTRIM_2V85 = 8'h88;
  localparam logic [7:0] OTCS_MTRIM_2V70 = 8'h8c;
  localparam logic [7:0] OTCS_STRIM_3V30 = 8'h10;
  localparam logic [7:0] OTCS_STRIM_3V00 = 8'h11;
  localparam logic [7:0] OTCS_STRIM_2V85 = 8'h12;
  localparam logic [7:0] OTCS_STRIM_2V70 = 8'h13;
  localparam logic [7:0] OTCS_GAIN_HIGH_V = 8'h40;
  localparam logic [7:0] OTCS_GAIN_LOW_V = 8'hff;
  localparam logic [7:0] OTCS_MAIN_GAIN_RST = OTCS_GAIN_HIGH_V;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OTCS_CLK_PERIOD_NS = 100;
  localparam int OTCS_SLOW_PERIOD_NS = 31250;
  localparam int OTCS_SLOW_DIV = OTCS_SLOW_PERIOD_NS / OTCS_CLK_PERIOD_NS;
  localparam logic [9:0] OTCS_SLOW_DIV_CYC = 10'(OTCS_SLOW_DIV);
  localparam logic [9:0] OTCS_LP_EXTRA_CYC = 10'h020;
  localparam logic [7:0] OTCS_WAKE_TICKS = 8'h10;
  localparam logic [11:0] OTCS_INTERVAL_RELOAD = 12'hfff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic suspend;
    logic capture_slow;
    logic interval_slow;
    logic slow_normal;
  } otcs_cfg_s;

  localparam otcs_cfg_s OTCS_CFG_RST = '{default: 1'b0};

  typedef enum logic [1:0] {
    OTCS_IDLE = 2'b01,
    OTCS_LOAD = 2'b10
  } otcs_state_e;

endpackage

// ==== core/otcs_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module otcs_tick_div (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] period,
  output logic tick
);
  import otcs_pkg::*;

  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // A shorter period written mid-count is caught by the >= compare
  always_comb begin
    cnt_nxt = cnt_r + 10'h001;
    tick_nxt = 1'b0;
    if (cnt_r >= period - 10'h001) begin
      cnt_nxt = 10'h000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 10'h000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // otcs_tick_div
`default_nettype wire

// ==== core/otcs_clock_ctrl.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module otcs_clock_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic main_osc_enable,
  output logic [7:0] main_osc_trim_out,
  output logic [7:0] main_osc_gain_out,
  output logic [7:0] slow_osc_trim_out,
  output logic slow_osc_normal_mode,
  output logic slow_clk_tick,
  output logic wakeup_pulse,
  output logic interval_timer_clock_tick,
  output logic capture_timer_clock_tick,
  output otcs_pkg::otcs_cfg_s cfg_out
);
  import otcs_pkg::*;

  // ----------------------------------------------------------------
  // Supervisory table lookup
  // ----------------------------------------------------------------
  function automatic logic [7:0] rom_byte(input logic [2:0] tbl,
                                          input logic [2:0] slot);
    logic [7:0] b;
    b = 8'h00;
    if (tbl == OTCS_TBL_ID) begin
      if (slot == 3'(OTCS_SLOT_F8)) b = OTCS_SILICON_ID[15:8];
      if (slot == 3'(OTCS_SLOT_F9)) b = OTCS_SILICON_ID[7:0];
    end else if (tbl == OTCS_TBL_MAIN) begin
      if (slot == 3'(OTCS_SLOT_FC)) b = OTCS_MTRIM_3V30;
      if (slot == 3'(OTCS_SLOT_FD)) b = OTCS_MTRIM_3V00;
      if (slot == 3'(OTCS_SLOT_FE)) b = OTCS_MTRIM_2V85;
      if (slot == 3'(OTCS_SLOT_FF)) b = OTCS_MTRIM_2V70;
    end else if (tbl == OTCS_TBL_SLOW) begin
      if (slot == 3'(OTCS_SLOT_F8)) b = OTCS_STRIM_3V30;
      if (slot == 3'(OTCS_SLOT_F9)) b = OTCS_STRIM_3V00;
      if (slot == 3'(OTCS_SLOT_FA)) b = OTCS_STRIM_2V85;
      if (slot == 3'(OTCS_SLOT_FB)) b = OTCS_STRIM_2V70;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [7:0] mtrim_r;
  logic [7:0] mtrim_nxt;
  logic [7:0] mgain_r;
  logic [7:0] mgain_nxt;
  logic [7:0] strim_r;
  logic [7:0] strim_nxt;
  otcs_cfg_s cfg_r;
  otcs_cfg_s cfg_nxt;
  otcs_state_e state_r;
  otcs_state_e state_nxt;
  logic [2:0] tbl_r;
  logic [2:0] tbl_nxt;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic err_r;
  logic err_nxt;
  logic [7:0] buf_r [8];
  logic [7:0] buf_nxt [8];
  logic [11:0] ivl_r;
  logic [11:0] ivl_nxt;
  logic [7:0] wake_cnt_r;
  logic [7:0] wake_cnt_nxt;
  logic wake_r;
  logic wake_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [9:0] slow_period;
  logic slow_tick;
  logic main_tick;
  logic ivl_tick;
  logic cap_tick;
  logic cmd_ok;
  logic [7:0] cmd_key;
  logic [7:0] cmd_op;
  logic [2:0] buf_sel;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign cmd_key = pwdata[OTCS_CMD_KEY_LSB +: 8];
  assign cmd_op = pwdata[OTCS_CMD_OP_LSB +: 8];
  assign cmd_ok = (cmd_key == OTCS_TBL_KEY) && (cmd_op == OTCS_TBL_OP);
  assign buf_sel = paddr[4:2];

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  // Low-power mode trades accuracy for current: trim is not applied
  always_comb begin
    slow_period = OTCS_SLOW_DIV_CYC + OTCS_LP_EXTRA_CYC;
    if (cfg_r.slow_normal) begin
      slow_period = OTCS_SLOW_DIV_CYC - {6'h00, strim_r[7:4]};
    end
  end

  otcs_tick_div u_slow_osc (
    .clk(clk),
    .rst_b(rst_b),
    .period(slow_period),
    .tick(slow_tick)
  );

  // Main oscillator stops in suspend; the slow tick keeps running
  assign main_tick = ~cfg_r.suspend;
  assign cap_tick = cfg_r.capture_slow ? slow_tick : main_tick;
  assign ivl_tick = cfg_r.interval_slow ? slow_tick : main_tick;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    mtrim_nxt = mtrim_r;
    mgain_nxt = mgain_r;
    strim_nxt = strim_r;
    cfg_nxt = cfg_r;
    if (wr_en) begin
      if (paddr == OTCS_OFF_MAIN_TRIM) begin
        mtrim_nxt = pwdata[7:0];
      end else if (paddr == OTCS_OFF_MAIN_GAIN) begin
        mgain_nxt = pwdata[7:0];
      end else if (paddr == OTCS_OFF_SLOW_TRIM) begin
        strim_nxt = pwdata[7:0];
      end else if (paddr == OTCS_OFF_CLK_CFG) begin
        cfg_nxt = otcs_cfg_s'(pwdata[3:0]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mtrim_r <= OTCS_MTRIM_3V30;
      mgain_r <= OTCS_MAIN_GAIN_RST;
      strim_r <= OTCS_STRIM_3V30;
      cfg_r <= OTCS_CFG_RST;
    end else begin
      mtrim_r <= mtrim_nxt;
      mgain_r <= mgain_nxt;
      strim_r <= strim_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Table read engine
  // ----------------------------------------------------------------
  // One byte per cycle; a new command while busy is ignored
  always_comb begin
    state_nxt = state_r;
    tbl_nxt = tbl_r;
    idx_nxt = idx_r;
    err_nxt = err_r;
    for (int i = 0; i < 8; i++) begin
      buf_nxt[i] = buf_r[i];
    end
    case (state_r)
      OTCS_IDLE: begin
        if (wr_en && paddr == OTCS_OFF_TBL_CMD) begin
          err_nxt = ~cmd_ok;
          if (cmd_ok) begin
            tbl_nxt = pwdata[OTCS_CMD_BLK_LSB +: 3];
            idx_nxt = 3'h0;
            state_nxt = OTCS_LOAD;
          end
        end
      end
      OTCS_LOAD: begin
        buf_nxt[idx_r] = rom_byte(tbl_r, idx_r);
        idx_nxt = idx_r + 3'h1;
        if (idx_r == 3'h7) begin
          state_nxt = OTCS_IDLE;
        end
      end
      default: begin
        state_nxt = OTCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= OTCS_IDLE;
      tbl_r <= 3'h0;
      idx_r <= 3'h0;
      err_r <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      tbl_r <= tbl_nxt;
      idx_r <= idx_nxt;
      err_r <= err_nxt;
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= buf_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wakeup and interval counter
  // ----------------------------------------------------------------
  // The interval counter may move between two reads on the slow clock
  always_comb begin
    ivl_nxt = ivl_r;
    wake_cnt_nxt = wake_cnt_r;
    wake_nxt = 1'b0;
    if (ivl_tick) begin
      ivl_nxt = (ivl_r == 12'h000) ? OTCS_INTERVAL_RELOAD
                                   : ivl_r - 12'h001;
    end
    if (!cfg_r.suspend) begin
      wake_cnt_nxt = 8'h00;
    end else if (slow_tick) begin
      wake_cnt_nxt = wake_cnt_r + 8'h01;
      if (wake_cnt_r == OTCS_WAKE_TICKS - 8'h01) begin
        wake_cnt_nxt = 8'h00;
        wake_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ivl_r <= OTCS_INTERVAL_RELOAD;
      wake_cnt_r <= 8'h00;
      wake_r <= 1'b0;
    end else begin
      ivl_r <= ivl_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      wake_r <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      rdata_nxt = 32'h0000_0000;
      if (paddr == OTCS_OFF_MAIN_TRIM) begin
        rdata_nxt[7:0] = mtrim_r;
      end else if (paddr == OTCS_OFF_MAIN_GAIN) begin
        rdata_nxt[7:0] = mgain_r;
      end else if (paddr == OTCS_OFF_SLOW_TRIM) begin
        rdata_nxt[7:0] = strim_r;
      end else if (paddr == OTCS_OFF_CLK_CFG) begin
        rdata_nxt[3:0] = cfg_r;
      end else if (paddr == OTCS_OFF_TBL_CMD) begin
        rdata_nxt[OTCS_CMD_BLK_LSB +: 3] = tbl_r;
        rdata_nxt[OTCS_CMD_BUSY_BIT] = (state_r == OTCS_LOAD);
        rdata_nxt[OTCS_CMD_ERR_BIT] = err_r;
      end else if (paddr == OTCS_OFF_INTERVAL) begin
        rdata_nxt[11:0] = ivl_r;
      end else if (paddr >= OTCS_OFF_TBL_BUF && paddr <= OTCS_OFF_TBL_END
                   && paddr[1:0] == 2'b00) begin
        rdata_nxt[7:0] = buf_r[buf_sel];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data is presented combinationally via rdata_nxt, so it is valid at access;
  // rdata_r keeps the last read value and is held when no read is under way.
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = 1'b1;
      if (paddr == OTCS_OFF_MAIN_TRIM || paddr == OTCS_OFF_MAIN_GAIN ||
          paddr == OTCS_OFF_SLOW_TRIM || paddr == OTCS_OFF_CLK_CFG ||
          paddr == OTCS_OFF_TBL_CMD || paddr == OTCS_OFF_INTERVAL) begin
        pslverr = 1'b0;
      end else if (paddr >= OTCS_OFF_TBL_BUF && paddr <= OTCS_OFF_TBL_END
                   && paddr[1:0] == 2'b00) begin
        pslverr = 1'b0;
      end
    end
  end

  assign prdata = rdata_nxt;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign main_osc_enable = ~cfg_r.suspend;
  assign main_osc_trim_out = mtrim_r;
  assign main_osc_gain_out = mgain_r;
  assign slow_osc_trim_out = strim_r;
  assign slow_osc_normal_mode = cfg_r.slow_normal;
  assign slow_clk_tick = slow_tick;
  assign wakeup_pulse = wake_r;
  assign interval_timer_clock_tick = ivl_tick;
  assign capture_timer_clock_tick = cap_tick;
  assign cfg_out = cfg_r;
endmodule // otcs_clock_ctrl
`default_nettype wire

// ==== core/otcs_unused_note_placeholder_never.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/otcs_clock_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module otcs_props_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic main_osc_enable,
  input wire logic [7:0] main_osc_trim_out,
  input wire logic [7:0] main_osc_gain_out,
  input wire logic slow_clk_tick,
  input wire logic wakeup_pulse,
  input wire logic interval_timer_clock_tick,
  input wire logic capture_timer_clock_tick,
  input wire otcs_pkg::otcs_cfg_s cfg_out
);
  import otcs_pkg::*;
  default clocking dck @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic [7:0] wlo;
  assign acc = psel && penable;
  assign wlo = pwdata[7:0];
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  trim_reset_a: assert property (
    $rose(rst_b) |-> main_osc_trim_out == OTCS_MTRIM_3V30)
    else $error("Main trim not at supply default after reset");
  trim_write_a: assert property (
    acc && pwrite && paddr == OTCS_OFF_MAIN_TRIM |=>
    main_osc_trim_out == $past(wlo)) else $error("Trim write lost");
  gain_write_a: assert property (
    acc && pwrite && paddr == OTCS_OFF_MAIN_GAIN |=>
    main_osc_gain_out == $past(wlo)) else $error("Gain write lost");
  trim_read_a: assert property (
    acc && !pwrite && paddr == OTCS_OFF_MAIN_TRIM |->
    prdata == {24'h0, main_osc_trim_out}) else $error("Trim readback");
  zero_wait_a: assert property (acc |-> pready)
    else $error("Access phase without ready");
  unmapped_err_a: assert property (
    acc && paddr == 8'h50 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("Unmapped access not refused");
  ival_src_a: assert property (
    cfg_out.interval_slow |-> interval_timer_clock_tick == slow_clk_tick)
    else $error("Interval clock not on slow tick");
  cap_src_a: assert property (
    cfg_out.capture_slow |-> capture_timer_clock_tick == slow_clk_tick)
    else $error("Capture clock not on slow tick");
  slow_pulse_a: assert property (
    slow_clk_tick |=> (!slow_clk_tick) [*8])
    else $error("Slow tick too long");
  osc_stop_a: assert property (
    cfg_out.suspend |-> !main_osc_enable &&
    (cfg_out.interval_slow || !interval_timer_clock_tick) &&
    (cfg_out.capture_slow || !capture_timer_clock_tick))
    else $error("Main osc on in suspend");
  wake_gate_a: assert property (
    wakeup_pulse |-> cfg_out.suspend || $past(cfg_out.suspend))
    else $error("Wakeup outside suspend");
  trim_cover: cover property (acc && pwrite && paddr == OTCS_OFF_MAIN_TRIM);
  wake_cover: cover property (wakeup_pulse);
  ival_cover: cover property (cfg_out.interval_slow && slow_clk_tick);
endmodule // otcs_props_chk
`default_nettype wire

// ==== tb/oscillator_trim_and_clock_sources_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module oscillator_trim_and_clock_sources_bench;
  import otcs_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic main_osc_enable, slow_osc_normal_mode, slow_clk_tick, wakeup_pulse;
  logic interval_timer_clock_tick, capture_timer_clock_tick;
  logic [7:0] paddr, main_osc_trim_out, main_osc_gain_out, slow_osc_trim_out;
  logic [31:0] pwdata, prdata, rd;
  otcs_cfg_s cfg_out;
  int mismatches, checks_done;
  logic [7:0] mt [4];
  logic [7:0] st [4];

  otcs_clock_ctrl DUT (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_osc_enable(main_osc_enable),
    .main_osc_trim_out(main_osc_trim_out),
    .main_osc_gain_out(main_osc_gain_out),
    .slow_osc_trim_out(slow_osc_trim_out),
    .slow_osc_normal_mode(slow_osc_normal_mode),
    .slow_clk_tick(slow_clk_tick), .wakeup_pulse(wakeup_pulse),
    .interval_timer_clock_tick(interval_timer_clock_tick),
    .capture_timer_clock_tick(capture_timer_clock_tick),
    .cfg_out(cfg_out)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Entered right after a rising edge; one idle edge follows the taking
  // edge so that back-to-back calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Syncs on two pulses so a period begun under the old setting is skipped
  task automatic gap(input logic wk, output int n);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((wk ? wakeup_pulse : slow_clk_tick) !== 1'b1 && n < 6000);
      if (n >= 6000) begin
        mismatches++;
        end_of_test();
      end
    end
  endtask

  function automatic logic [7:0] tbl_byte(input logic [2:0] t, input int s);
    if (t == OTCS_TBL_ID && s == 0) return OTCS_SILICON_ID[15:8];
    if (t == OTCS_TBL_ID && s == 1) return OTCS_SILICON_ID[7:0];
    if (t == OTCS_TBL_MAIN && s >= 4) return mt[s - 4];
    if (t == OTCS_TBL_SLOW && s < 4) return st[s];
    return 8'h00;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OTCS_OFF_MAIN_TRIM, 32'h0);
    chk(rd, {24'h0, OTCS_MTRIM_3V30});
    apb(1'b0, OTCS_OFF_MAIN_GAIN, 32'h0);
    chk(rd, {24'h0, OTCS_MAIN_GAIN_RST});
    chk(slow_osc_trim_out, OTCS_STRIM_3V30);
    apb(1'b0, 8'h50, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h50, 32'hff);
    chk(er, 1'b1);
  endtask

  task automatic t_trim();
    logic [7:0] g;
    for (int i = 0; i < 4; i++) begin
      g = (i < 2) ? OTCS_GAIN_HIGH_V : OTCS_GAIN_LOW_V;
      apb(1'b1, OTCS_OFF_MAIN_TRIM, {24'h0, mt[i]});
      apb(1'b1, OTCS_OFF_MAIN_GAIN, {24'h0, g});
      #1 chk(main_osc_trim_out, mt[i]);
      chk(main_osc_gain_out, g);
      @(posedge clk);
      apb(1'b0, OTCS_OFF_MAIN_TRIM, 32'h0);
      chk(rd, {24'h0, mt[i]});
      apb(1'b0, OTCS_OFF_MAIN_GAIN, 32'h0);
      chk(rd, {24'h0, g});
    end
  endtask

  task automatic t_tables();
    int n;
    apb(1'b1, OTCS_OFF_TBL_CMD, {8'h0, OTCS_TBL_OP, 8'h3b, 8'h02});
    apb(1'b0, OTCS_OFF_TBL_CMD, 32'h0);
    chk(rd[OTCS_CMD_ERR_BIT], 1'b1);
    apb(1'b1, OTCS_OFF_TBL_CMD, {8'h0, 8'h07, OTCS_TBL_KEY, 8'h02});
    apb(1'b0, OTCS_OFF_TBL_CMD, 32'h0);
    chk(rd[OTCS_CMD_ERR_BIT], 1'b1);
    for (int t = 0; t < 4; t++) begin
      // Upper table-number bits set on purpose: they must not matter
      apb(1'b1, OTCS_OFF_TBL_CMD,
          {8'h0, OTCS_TBL_OP, OTCS_TBL_KEY, 5'h15, 3'(t)});
      n = 0;
      do begin
        apb(1'b0, OTCS_OFF_TBL_CMD, 32'h0);
        n++;
      end while (rd[OTCS_CMD_BUSY_BIT] !== 1'b0 && n < 16);
      chk(rd[25:24], 2'b00);
      for (int s = 0; s < 8; s++) begin
        apb(1'b0, OTCS_OFF_TBL_BUF + 8'(4 * s), 32'h0);
        chk(rd, {24'h0, tbl_byte(3'(t), s)});
      end
    end
  endtask

  task automatic t_clocks();
    int n;
    logic [31:0] w;
    apb(1'b1, OTCS_OFF_SLOW_TRIM, 32'h30);
    apb(1'b1, OTCS_OFF_CLK_CFG, 32'h7);
    #1 chk(slow_osc_normal_mode, 1'b1);
    gap(1'b0, n);
    chk(32'(n), 32'd309);
    apb(1'b1, OTCS_OFF_CLK_CFG, 32'h6);
    gap(1'b0, n);
    chk(32'(n), 32'd344);
    apb(1'b1, OTCS_OFF_CLK_CFG, 32'he);
    #1 chk(main_osc_enable, 1'b0);
    gap(1'b1, n);
    chk(32'(n), 32'd5504);
    apb(1'b1, OTCS_OFF_CLK_CFG, 32'h2);
    #1 chk(main_osc_enable, 1'b1);
    @(posedge clk);
    n = 0;
    do begin
      apb(1'b0, OTCS_OFF_INTERVAL, 32'h0);
      w = rd;
      apb(1'b0, OTCS_OFF_INTERVAL, 32'h0);
      n++;
    end while (rd !== w && n < 8);
    chk(rd, w);
    chk(rd[31:12], 20'h0);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_b = 1'b0;
    mismatches = 0;
    checks_done = 0;
    mt = '{OTCS_MTRIM_3V30, OTCS_MTRIM_3V00, OTCS_MTRIM_2V85, OTCS_MTRIM_2V70};
    st = '{OTCS_STRIM_3V30, OTCS_STRIM_3V00, OTCS_STRIM_2V85, OTCS_STRIM_2V70};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_trim();
    t_tables();
    t_clocks();
    end_of_test();
  end
endmodule // oscillator_trim_and_clock_sources_bench

bind otcs_clock_ctrl otcs_props_chk u_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .main_osc_enable(main_osc_enable),
  .main_osc_trim_out(main_osc_trim_out),
  .main_osc_gain_out(main_osc_gain_out),
  .slow_clk_tick(slow_clk_tick), .wakeup_pulse(wakeup_pulse),
  .interval_timer_clock_tick(interval_timer_clock_tick),
  .capture_timer_clock_tick(capture_timer_clock_tick),
  .cfg_out(cfg_out)
);
`default_nettype wire
